// >>> design/rfsyn_map.svh
// Register offsets, field positions, reset values and timing counts for the synthesiser control.
//
// How it works
// R1 - Each channel keeps two divide pairs, transmit set and receive set.
// R2 - One control write flips a channel between its two divide sets.
// R3 - Feedback divide counter is 20 bits; reference divide counter is 13 bits.
// R4 - Reference source picks crystal or dedicated clock input, shared by both channels.
// R5 - Host writes divide values per channel and set; reads per-channel status.
// R6 - Reference and feedback dividers both divide down to the comparison rate.
// R7 - Locked output frequency equals feedback over reference times reference frequency.
// R8 - Comparison step programmable from 2.5kHz up to 200kHz.
// R9 - Each channel has a phase-frequency detector with lock detect, readable.
// R10 - Locked to out-of-lock transition is caught and signalled as an interrupt.
// R11 - Charge pump gain bit at bit 3 or bit 11 picks four-to-one current.
// R12 - Host needs four data writes; partial contents persist until the last.
// R13 - Host should rewrite only idle or unselected sets; no interlock exists.
// R14 - Both sets are independent; control register picks which drives each channel.
// R15 - Lock tolerance is one or four undivided reference clock cycles.
// R16 - Lock status is majority of last three measurements.
// R17 - Lock status bits readable in status register and maskable onto interrupt.
// R18 - Unselected set writes leave active counters alone; set loads at cycle boundary.
`ifndef RFSYN_MAP_SVH
`define RFSYN_MAP_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define RFSYN_ADDR_DATA 8'hb2
`define RFSYN_ADDR_CTRL 8'hb3
`define RFSYN_ADDR_STAT 8'hb4

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define RFSYN_N_W 20
`define RFSYN_R_W 13
`define RFSYN_DATA_CH_BIT 15
`define RFSYN_DATA_SET_BIT 14
`define RFSYN_DATA_WORD_MSB 13
`define RFSYN_DATA_WORD_LSB 12
`define RFSYN_CTRL_CH2_LSB 8
`define RFSYN_CTRL_EN_BIT 0
`define RFSYN_CTRL_SET_BIT 1
`define RFSYN_CTRL_TOL_BIT 2
`define RFSYN_CTRL_GAIN_BIT 3
`define RFSYN_CTRL_IRQEN_BIT 4
`define RFSYN_CTRL_REFSEL_BIT 7
`define RFSYN_STAT_LOCK_LSB 0
`define RFSYN_STAT_LOST_LSB 2
`define RFSYN_STAT_SET_LSB 4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RFSYN_CTRL_RESET 16'h0000
`define RFSYN_N_RESET 20'h0_0001
`define RFSYN_R_RESET 13'h0001
`define RFSYN_TOL_NARROW 3'h1
`define RFSYN_TOL_WIDE 3'h4
`endif

// >>> design/rfsyn_pkg.sv
// Types shared by the synthesiser control.
package rfsyn_pkg;

  // --------------------------------------------------------------------------
  // Divide pair and channel control
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [19:0] n_div;
    logic [12:0] r_div;
  } rfsyn_pair_s;

  typedef struct packed {
    logic irq_en;
    logic gain_hi;
    logic wide_tol;
    logic use_rx;
    logic enable;
  } rfsyn_chctl_s;

  typedef enum logic [1:0] {
    RFSYN_IDLE,
    RFSYN_RUN
  } rfsyn_state_e;

endpackage : rfsyn_pkg

// >>> design/rfsyn_top.sv
// Two-channel integer-N synthesiser divider, lock detect and register control.
`timescale 1ns/10ps
`include "rfsyn_map.svh"

module rfsyn_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Reference sources, taken as enables at the system clock
  input wire logic xtal_ref_tick,
  input wire logic dedicated_synth_clock_input,
  // Divided VCO edges per channel
  input wire logic [1:0] vco_tick,
  // Phase detector and charge pump drive per channel
  output logic [1:0] pd_up,
  output logic [1:0] pd_down,
  output logic [1:0] cp_gain_hi,
  output logic [1:0] cp_enable,
  // Lock loss interrupt
  output logic lock_irq
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  rfsyn_pkg::rfsyn_pair_s sets_ff [2][2];
  rfsyn_pkg::rfsyn_chctl_s ctl_ff [2];
  logic refsel_ff;
  logic [1:0] lost_ff;
  logic ref_tick;

  // Data word: bit 15 channel, bit 14 set, bits 13:12 word index, 12 bits payload.
  // Words 0,1 load N (low 12 then high 8); words 2,3 load R (low 12 then high 1).
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        for (int s = 0; s < 2; s++)
        begin
          sets_ff[c][s].n_div <= `RFSYN_N_RESET;
          sets_ff[c][s].r_div <= `RFSYN_R_RESET;
        end
      end
    end
    else if (reg_wr && reg_addr == `RFSYN_ADDR_DATA) // R5 R12 R13
    begin
      case (reg_wdata[`RFSYN_DATA_WORD_MSB:`RFSYN_DATA_WORD_LSB])
        2'd0: sets_ff[reg_wdata[`RFSYN_DATA_CH_BIT]][reg_wdata[`RFSYN_DATA_SET_BIT]]
          .n_div[11:0] <= reg_wdata[11:0];
        2'd1: sets_ff[reg_wdata[`RFSYN_DATA_CH_BIT]][reg_wdata[`RFSYN_DATA_SET_BIT]]
          .n_div[19:12] <= reg_wdata[7:0];
        2'd2: sets_ff[reg_wdata[`RFSYN_DATA_CH_BIT]][reg_wdata[`RFSYN_DATA_SET_BIT]]
          .r_div[11:0] <= reg_wdata[11:0];
        default: sets_ff[reg_wdata[`RFSYN_DATA_CH_BIT]][reg_wdata[`RFSYN_DATA_SET_BIT]]
          .r_div[12] <= reg_wdata[0];
      endcase
    end
  end

  // Control: low byte channel 1, high byte channel 2; bit 7 picks the reference.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_ff[0] <= '0;
      ctl_ff[1] <= '0;
      refsel_ff <= 1'b0;
    end
    else if (reg_wr && reg_addr == `RFSYN_ADDR_CTRL)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ctl_ff[c] <= reg_wdata[c*8 +: 5]; // R2 R11 R14
      end
      refsel_ff <= reg_wdata[`RFSYN_CTRL_REFSEL_BIT]; // R4
    end
  end

  // One shared reference feeds both channels.
  assign ref_tick = refsel_ff ? dedicated_synth_clock_input : xtal_ref_tick; // R4

  // --------------------------------------------------------------------------
  // Per-channel dividers, phase detector and lock detect
  // --------------------------------------------------------------------------
  rfsyn_pkg::rfsyn_pair_s act_ff [2];
  logic [19:0] ncnt_ff [2];
  logic [12:0] rcnt_ff [2];
  logic [1:0] rref_ff;
  logic [1:0] nfb_ff;
  logic [2:0] hist_ff [2];
  logic [1:0] lock_ff;
  logic [3:0] gap_ff [2];
  logic [1:0] r_edge;
  logic [1:0] n_edge;

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    // R6 R7 R3: both counters reload on terminal count, giving Fref/R and Fvco/N.
    assign r_edge[c] = ref_tick && (rcnt_ff[c] <= 13'd1);
    assign n_edge[c] = vco_tick[c] && (ncnt_ff[c] <= 20'd1);

    // R18: the chosen set is copied in when the reference cycle ends, and every cycle while the channel is disabled.
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        act_ff[c].n_div <= `RFSYN_N_RESET;
        act_ff[c].r_div <= `RFSYN_R_RESET;
      end
      else if (r_edge[c] || !ctl_ff[c].enable)
      begin
        act_ff[c] <= sets_ff[c][ctl_ff[c].use_rx]; // R1 R14 R18
      end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rcnt_ff[c] <= `RFSYN_R_RESET;
      end
      else if (!ctl_ff[c].enable)
      begin
        rcnt_ff[c] <= act_ff[c].r_div;
      end
      else if (ref_tick)
      begin
        rcnt_ff[c] <= r_edge[c] ? sets_ff[c][ctl_ff[c].use_rx].r_div : rcnt_ff[c] - 13'd1; // R8
      end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ncnt_ff[c] <= `RFSYN_N_RESET;
      end
      else if (!ctl_ff[c].enable)
      begin
        ncnt_ff[c] <= act_ff[c].n_div;
      end
      else if (vco_tick[c])
      begin
        ncnt_ff[c] <= n_edge[c] ? act_ff[c].n_div : ncnt_ff[c] - 20'd1; // R3
      end
    end

    // R9: phase-frequency detector, both flags clear when both have fired.
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        rref_ff[c] <= 1'b0;
        nfb_ff[c] <= 1'b0;
      end
      else if (!ctl_ff[c].enable)
      begin
        rref_ff[c] <= 1'b0;
        nfb_ff[c] <= 1'b0;
      end
      else
      begin
        rref_ff[c] <= (rref_ff[c] | r_edge[c]) & ~(nfb_ff[c] | n_edge[c]) | (r_edge[c] & ~nfb_ff[c] & ~n_edge[c]);
        nfb_ff[c] <= (nfb_ff[c] | n_edge[c]) & ~(rref_ff[c] | r_edge[c]) | (n_edge[c] & ~rref_ff[c] & ~r_edge[c]);
      end
    end

    // R15: count undivided reference ticks between the two edges of a comparison.
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        gap_ff[c] <= 4'h0;
        hist_ff[c] <= 3'b000;
      end
      else if (!ctl_ff[c].enable)
      begin
        gap_ff[c] <= 4'h0;
        hist_ff[c] <= 3'b000;
      end
      else if ((rref_ff[c] || nfb_ff[c]) && !(r_edge[c] || n_edge[c]))
      begin
        if (ref_tick && gap_ff[c] != 4'hf)
        begin
          gap_ff[c] <= gap_ff[c] + 4'h1;
        end
      end
      else if (r_edge[c] || n_edge[c])
      begin
        if (rref_ff[c] || nfb_ff[c] || (r_edge[c] && n_edge[c]))
        begin
          hist_ff[c] <= {hist_ff[c][1:0],
            gap_ff[c] < {1'b0, ctl_ff[c].wide_tol ? `RFSYN_TOL_WIDE : `RFSYN_TOL_NARROW}}; // R15
          gap_ff[c] <= 4'h0;
        end
      end
    end

    // R16: majority of the last three measurements.
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        lock_ff[c] <= 1'b0;
      end
      else
      begin
        lock_ff[c] <= (hist_ff[c][0] & hist_ff[c][1]) | (hist_ff[c][1] & hist_ff[c][2])
          | (hist_ff[c][0] & hist_ff[c][2]); // R16
      end
    end

    // R10: sticky lock-loss flag; a new loss wins over the clear-on-read.
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        lost_ff[c] <= 1'b0;
      end
      else if (lock_ff[c] && !((hist_ff[c][0] & hist_ff[c][1]) | (hist_ff[c][1] & hist_ff[c][2])
        | (hist_ff[c][0] & hist_ff[c][2])))
      begin
        lost_ff[c] <= 1'b1; // R10
      end
      else if (reg_rd && reg_addr == `RFSYN_ADDR_STAT)
      begin
        lost_ff[c] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pd_up[c] <= 1'b0;
        pd_down[c] <= 1'b0;
        cp_gain_hi[c] <= 1'b0;
        cp_enable[c] <= 1'b0;
      end
      else
      begin
        pd_up[c] <= rref_ff[c]; // R9
        pd_down[c] <= nfb_ff[c];
        cp_gain_hi[c] <= ctl_ff[c].gain_hi; // R11
        cp_enable[c] <= ctl_ff[c].enable;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status read and interrupt
  // --------------------------------------------------------------------------
  // Reads of unmapped addresses return zero so a stray read is harmless.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      lock_irq <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= (reg_addr == `RFSYN_ADDR_STAT) ?
          {8'h00, 2'b00, ctl_ff[1].use_rx, ctl_ff[0].use_rx, lost_ff, lock_ff} : 16'h0000; // R9 R17
      end
      lock_irq <= |(lost_ff & {ctl_ff[1].irq_en, ctl_ff[0].irq_en}); // R10 R17
    end
  end

endmodule : rfsyn_top

// >>> test/rfsyn_top_props.sv
// Port assertions for the synthesiser control.
`timescale 1ns/10ps
`include "rfsyn_map.svh"
module rfsyn_top_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Charge pump controls
  input wire logic [1:0] cp_gain_hi,
  input wire logic [1:0] cp_enable
);
  logic ctrl_wr;
  logic [3:0] ctl_ff;
  assign ctrl_wr = reg_wr && reg_addr == `RFSYN_ADDR_CTRL;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_ff <= 4'h0;
    else if (ctrl_wr)
      ctl_ff <= {reg_wdata[11], reg_wdata[3], reg_wdata[8], reg_wdata[0]};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_write;
    ctrl_wr;
  endsequence
  sequence read_answer;
    reg_rd ##1 reg_rvalid;
  endsequence
  chk_read_answer: assert property (reg_rd |-> read_answer)
    else $error("read not answered");
  chk_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  chk_upper_zero: assert property (reg_rvalid |-> reg_rdata[15:8] == 8'h00)
    else $error("status upper byte set");
  chk_unmapped_zero: assert property (reg_rd && reg_addr != `RFSYN_ADDR_STAT |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between reads");
  chk_gain_follows: assert property (ctrl_write |-> ##2 cp_gain_hi == ctl_ff[3:2])
    else $error("gain bit not applied");
  chk_enable_follows: assert property (ctrl_write |-> ##2 cp_enable == ctl_ff[1:0])
    else $error("enable bit not applied");
  chk_gain_quiet: assert property ($changed(cp_gain_hi) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("gain moved without write");
endmodule : rfsyn_top_props
bind rfsyn_top rfsyn_top_props i_rfsyn_top_props (.mclk(mclk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cp_gain_hi(cp_gain_hi),
  .cp_enable(cp_enable));

// >>> test/rfsyn_vco_model.sv
// Behavioural VCO and prescaler for both channels.
`timescale 1ns/10ps
module rfsyn_vco_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Loop drive and fault injection
  input wire logic [1:0] pd_up,
  input wire logic [1:0] pd_down,
  input wire logic fault,
  // Prescaled edges
  output logic [1:0] vco_tick
);
  logic [3:0] cnt [2];
  // Bang-bang tuning keeps the model small; it jitters a cycle or two at lock.
  always @(posedge mclk or negedge rst_n)
  begin
    for (int c = 0; c < 2; c++)
    begin
      vco_tick[c] <= rst_n && cnt[c] == 4'h0;
      if (!rst_n || cnt[c] == 4'h0)
        cnt[c] <= fault ? 4'hf : pd_up[c] ? 4'h6 : pd_down[c] ? 4'h8 : 4'h7;
      else
        cnt[c] <= cnt[c] - 4'h1;
    end
  end
endmodule : rfsyn_vco_model

// >>> test/rfsyn_top_tb.sv
// Self-checking bench for the synthesiser control.
`timescale 1ns/10ps
`include "rfsyn_map.svh"
module rfsyn_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, d;
  logic reg_rvalid, lock_irq;
  logic xtal_ref_tick = 1'b0;
  logic dedicated_synth_clock_input = 1'b0;
  logic [1:0] vco_tick, pd_up, pd_down, cp_gain_hi, cp_enable;
  logic fault = 1'b0;
  logic use_ded = 1'b0;
  logic [31:0] lfsr = 32'h0000_a184;
  int cyc = 0;
  int n_fail = 0;
  int n_compared = 0;
  always #12.5 mclk = !mclk;
  rfsyn_top i_rfsyn_top (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .xtal_ref_tick(xtal_ref_tick),
    .dedicated_synth_clock_input(dedicated_synth_clock_input), .vco_tick(vco_tick),
    .pd_up(pd_up), .pd_down(pd_down), .cp_gain_hi(cp_gain_hi), .cp_enable(cp_enable),
    .lock_irq(lock_irq));
  rfsyn_vco_model i_rfsyn_vco_model (.mclk(mclk), .rst_n(rst_n), .pd_up(pd_up),
    .pd_down(pd_down), .fault(fault), .vco_tick(vco_tick));
  // --------------------------------------------------
  // Reference ticks and hang limit
  // --------------------------------------------------
  // With the dedicated input selected the crystal runs at another rate so a wrong selection shows; otherwise the dedicated input stays low.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    xtal_ref_tick <= use_ded ? cyc % 3 == 0 : cyc % 4 == 3;
    dedicated_synth_clock_input <= use_ded && cyc % 4 == 3;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  function automatic logic [15:0] stat(input logic lk, input logic lost, input logic rx);
    return {11'h000, rx, 1'b0, lost, 1'b0, lk};
  endfunction : stat
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic st(input string what, input logic [15:0] exp);
    rd(`RFSYN_ADDR_STAT);
    chk(what, exp, d);
  endtask : st
  task automatic prog(input logic rx, input logic [19:0] n, input logic [12:0] r);
    wr(`RFSYN_ADDR_DATA, {1'b0, rx, 2'h0, n[11:0]});
    wr(`RFSYN_ADDR_DATA, {1'b0, rx, 2'h1, 4'h0, n[19:12]});
    wr(`RFSYN_ADDR_DATA, {1'b0, rx, 2'h2, r[11:0]});
    wr(`RFSYN_ADDR_DATA, {1'b0, rx, 2'h3, 11'h000, r[12]});
  endtask : prog
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    st("reset status", stat(0, 0, 0));
    chk("reset cp_enable", 16'h0000, 16'(cp_enable));
    prog(1'b0, 20'h0_0004, 13'h0008);
    wr(`RFSYN_ADDR_CTRL, 16'h0815);
    repeat (3) @(posedge mclk);
    chk("cp_gain_hi", 16'h0002, 16'(cp_gain_hi));
    chk("cp_enable", 16'h0001, 16'(cp_enable));
    repeat (1500) @(posedge mclk);
    rd(`RFSYN_ADDR_STAT);
    st("tx lock", stat(1, 0, 0));
    prog(1'b1, 20'h0_0064, 13'h0008);
    repeat (300) @(posedge mclk);
    st("rx set written", stat(1, 0, 0));
    wr(`RFSYN_ADDR_CTRL, 16'h0817);
    repeat (3000) @(posedge mclk);
    chk("irq on loss", 16'h0001, 16'(lock_irq));
    st("rx loss", stat(0, 1, 1));
    st("lost cleared", stat(0, 0, 1));
    repeat (2) @(posedge mclk);
    chk("irq cleared", 16'h0000, 16'(lock_irq));
    wr(`RFSYN_ADDR_CTRL, 16'h0815);
    repeat (1500) @(posedge mclk);
    rd(`RFSYN_ADDR_STAT);
    st("tx again", stat(1, 0, 0));
    wr(`RFSYN_ADDR_CTRL, 16'h0895);
    use_ded <= 1'b1;
    repeat (1500) @(posedge mclk);
    rd(`RFSYN_ADDR_STAT);
    st("dedicated ref", stat(1, 0, 0));
    fault <= 1'b1;
    repeat (1500) @(posedge mclk);
    chk("irq on fault", 16'h0001, 16'(lock_irq));
    wr(`RFSYN_ADDR_CTRL, 16'h0885);
    repeat (3) @(posedge mclk);
    chk("irq masked", 16'h0000, 16'(lock_irq));
    st("fault", stat(0, 1, 0));
    for (int i = 0; i < 8; i++)
    begin
      lfsr = step(lfsr);
      wr({2'b11, lfsr[5:0]}, lfsr[31:16]);
      rd({2'b11, lfsr[5:0]});
      chk("unmapped read", 16'h0000, d);
    end
    st("after unmapped", stat(0, 0, 0));
    print_verdict();
  end
endmodule : rfsyn_top_tb
